// >>> ang_autoneg.v
/*
  auto-negotiation arbitration for one copper port: pulse timing checks,
  page exchange sequence, parallel detection and mode resolution, with an
  AXI4-Lite register slave; assumes a line receiver that reports pulses,
  decoded partner pages, 100 Mb/s idle and data-path link health
*/
`timescale 1ns/1ps
`default_nettype none
`include "ang_regs.vh"

// Operation
// - send bursts every 16 ms, pulses 68 us apart; clock pulses 17.2-185 us apart
// - accept partner bursts only 6.8 ms to 112 ms apart
// - a pulse 35.4-95 us after the previous pulse, clock or data, is a data pulse
// - normal link pulses count only when 4.5 ms to 30 ms apart
// - hold a parallel-detect candidate 830 ms before committing
// - wait 1000 ms in link-enable wait before link up
// - gigabit pages, then energy pages, then optional software pages
// - gigabit set is message code 8 plus two unformatted pages
// - first unformatted carries master-slave control, second the seed
// - resolved master-slave outcome written to master-slave status
// - gigabit pages are sent in every negotiation
// - energy set is code 10 plus one page; nonzero override replaces 10
// - energy page carries advertisement; partner page stored in partner register
// - skip the energy pages when the energy advertisement is zero
// - each exchanged next page shows in the next-page receive register
// - software pages follow only with the next-page bit; tracked via expansion
// - parallel-detected link defaults to half duplex
// - override bits force full duplex, one for 100 and one for 10
// - pick highest common mode, gigabit full down to 10 half
// - gigabit half duplex is never advertised
// - without bursts, detect 10 or 100 from fixed receiver signalling
// - advertisement changes apply at enable, restart, link loss, a dropped parallel-detect candidate or the end of link-enable wait
module ang_autoneg #(
  parameter TW     = 26,
  parameter C_TXB  = `ANG_CYC_US(`ANG_T_TXB_US),
  parameter C_FMAX = `ANG_CYC_US(`ANG_T_FLPMAX_US),
  parameter C_BMIN = `ANG_CYC_US(`ANG_T_RXBMIN_US),
  parameter C_BMAX = `ANG_CYC_US(`ANG_T_RXBMAX_US),
  parameter C_NMIN = `ANG_CYC_US(`ANG_T_NLPMIN_US),
  parameter C_NMAX = `ANG_CYC_US(`ANG_T_NLPMAX_US),
  parameter C_PD   = `ANG_CYC_US(`ANG_T_PD_US),
  parameter C_LEW  = `ANG_CYC_US(`ANG_T_LEW_US)
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rx_pulse,
  input  wire        rx_page_valid,
  input  wire [15:0] rx_page,
  input  wire        rx_idle_100,
  input  wire        link_ok,
  output wire        tx_pulse,
  output reg         link_up_r,
  output reg  [1:0]  speed_r,
  output reg         full_duplex_r
);

  localparam C_TXP = `ANG_CYC_US(`ANG_T_TXP_US);
  localparam C_FMIN = `ANG_CYC_NS_UP(`ANG_T_FLPMIN_NS);
  localparam C_DMIN = `ANG_CYC_NS_UP(`ANG_T_DATMIN_NS);
  localparam C_DMAX = `ANG_CYC_US(`ANG_T_DATMAX_US);
  localparam [TW-1:0] ONE = 1;

  localparam [3:0] S_DIS = 4'h0;
  localparam [3:0] S_ABIL = 4'h1;
  localparam [3:0] S_GBM = 4'h2;
  localparam [3:0] S_GB1 = 4'h3;
  localparam [3:0] S_GB2 = 4'h4;
  localparam [3:0] S_EEM = 4'h5;
  localparam [3:0] S_EEU = 4'h6;
  localparam [3:0] S_SW = 4'h7;
  localparam [3:0] S_PD = 4'h8;
  localparam [3:0] S_WAIT = 4'h9;
  localparam [3:0] S_UP = 4'ha;

  reg [15:0]   ctrl_r;
  reg [15:0]   adv_r;
  reg [15:0]   adv_act_r;
  reg [15:0]   lpa_r;
  reg [15:0]   nptx_r;
  reg [15:0]   nprx_r;
  reg [15:0]   msctl_r;
  reg [15:0]   msst_r;
  reg [15:0]   eeeadv_r;
  reg [15:0]   eeelp_r;
  reg [15:0]   eeecode_r;
  reg [15:0]   lpu1_r;
  reg [10:0]   seed_r;
  reg [1:0]    pdfd_r;
  reg          exp_pr_r;
  reg          sw_rdy_r;
  reg [3:0]    st_r;
  reg [TW-1:0] tmr_r;
  reg          cand100_r;
  reg          pd_r;
  reg [2:0]    clk_cnt_r;
  reg          over_d_r;
  reg          burst_ok_r;
  reg          nlp_ok_r;
  reg          flp_evt_r;
  reg          nlp_evt_r;
  reg          aw_got_r;
  reg          w_got_r;
  reg [7:0]    awa_r;
  reg [31:0]   wd_r;
  reg [3:0]    ws_r;
  reg [15:0]   rd_mux;
  reg [15:0]   txp;

  wire flp_hit;
  wire flp_over;
  wire dat_hit;
  wire rxb_hit;
  wire rxb_over;
  wire nlp_hit;
  wire nlp_over;

  function ang_hit;
    input [7:0] a;
    begin
      ang_hit = (a[1:0] == 2'b00) && (a <= `ANG_OFF_PDFD);
    end
  endfunction

  function [15:0] wmerge;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // master-slave resolution from own control, own seed and partner pages
  function [15:0] ms_res;
    input [15:0] ctl;
    input [10:0] sd;
    input [15:0] u1;
    input [15:0] u2;
    reg          mst;
    reg          flt;
    begin
      flt = 1'b0;
      if (ctl[`ANG_MS_MEN])
        mst = ctl[`ANG_MS_MVAL];
      else if (u1[4])
        mst = !u1[3];
      else begin
        mst = (sd > u2[10:0]);
        flt = (sd == u2[10:0]);
      end
      ms_res = 16'h0000;
      ms_res[`ANG_MSST_FAULT] = flt;
      ms_res[`ANG_MSST_MASTER] = mst;
      ms_res[`ANG_MSST_LPFD] = u1[1];
    end
  endfunction

  wire an_en = ctrl_r[`ANG_CTRL_ANEN];
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire restart = wr_go && (awa_r == `ANG_OFF_CTRL) && ws_r[1] && wd_r[`ANG_CTRL_RST];
  wire rx_ok = rx_page_valid && burst_ok_r;
  wire eee_on = (eeeadv_r != 16'h0000);
  wire sw_on = adv_act_r[`ANG_ADV_NP];
  wire [10:0] eee_code = (eeecode_r[10:0] != 11'h000) ? eeecode_r[10:0] : `ANG_EEE_CODE;
  wire flp_en = (st_r >= S_ABIL) && (st_r <= S_SW);
  wire gfd = msctl_r[`ANG_MS_FD] && lpu1_r[1] && !msst_r[`ANG_MSST_FAULT];
  wire c100f = adv_act_r[`ANG_ADV_100F] && lpa_r[`ANG_ADV_100F];
  wire c100h = adv_act_r[`ANG_ADV_100H] && lpa_r[`ANG_ADV_100H];
  wire c10f = adv_act_r[`ANG_ADV_10F] && lpa_r[`ANG_ADV_10F];
  wire c10h = adv_act_r[`ANG_ADV_10H] && lpa_r[`ANG_ADV_10H];

  ang_flp #(.TW(TW), .BURST(C_TXB), .PULSE(C_TXP)) u_flp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (flp_en),
    .page    (txp),
    .pulse_r (tx_pulse)
  );

  ang_ivl #(.TW(TW), .LO(C_FMIN), .HI(C_FMAX)) u_fivl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (rx_pulse),
    .hit_r   (flp_hit),
    .over    (flp_over)
  );

  ang_ivl #(.TW(TW), .LO(C_DMIN), .HI(C_DMAX)) u_divl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (rx_pulse),
    .hit_r   (dat_hit),
    .over    ()
  );

  ang_ivl #(.TW(TW), .LO(C_BMIN), .HI(C_BMAX)) u_bivl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (flp_evt_r),
    .hit_r   (rxb_hit),
    .over    (rxb_over)
  );

  ang_ivl #(.TW(TW), .LO(C_NMIN), .HI(C_NMAX)) u_nivl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (nlp_evt_r),
    .hit_r   (nlp_hit),
    .over    (nlp_over)
  );

  // burst classification: two or more clock spacings make a negotiation burst
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_cnt_r  <= 3'h0;
      over_d_r   <= 1'b1;
      burst_ok_r <= 1'b0;
      nlp_ok_r   <= 1'b0;
      flp_evt_r  <= 1'b0;
      nlp_evt_r  <= 1'b0;
    end else begin
      over_d_r  <= flp_over;
      flp_evt_r <= 1'b0;
      nlp_evt_r <= 1'b0;
      if (flp_over && !over_d_r) begin
        clk_cnt_r <= 3'h0;
        if (clk_cnt_r >= 3'h2)
          flp_evt_r <= 1'b1;
        else
          nlp_evt_r <= 1'b1;
      end else if (flp_hit && !dat_hit && clk_cnt_r != 3'h7) begin
        clk_cnt_r <= clk_cnt_r + 3'h1;
      end
      if (rxb_hit)
        burst_ok_r <= 1'b1;
      else if (rxb_over)
        burst_ok_r <= 1'b0;
      if (nlp_hit)
        nlp_ok_r <= 1'b1;
      else if (nlp_over)
        nlp_ok_r <= 1'b0;
    end
  end

  // page offered to the partner in each state
  always @* begin
    case (st_r)
      S_GBM: txp = {5'b10100, `ANG_GB_CODE};
      S_GB1: txp = {5'b10000, 6'h00, msctl_r[`ANG_MS_MEN:`ANG_MS_FD], 1'b0};
      S_GB2: txp = {eee_on || sw_on, 4'b0000, seed_r};
      S_EEM: txp = {5'b10100, eee_code};
      S_EEU: txp = {sw_on, 4'b0000, eeeadv_r[10:0]};
      S_SW: txp = nptx_r;
      default: txp = {1'b1, 1'b0, adv_act_r[13:0]};
    endcase
  end

  always @* begin
    case (s_axi_araddr)
      `ANG_OFF_CTRL: rd_mux = ctrl_r;
      `ANG_OFF_STAT: rd_mux = {st_r, msst_r[`ANG_MSST_MASTER], full_duplex_r, speed_r, 2'b00,
                               (st_r == S_UP) && !pd_r, 2'b00, link_up_r, 2'b00};
      `ANG_OFF_ADV: rd_mux = adv_r;
      `ANG_OFF_LPA: rd_mux = lpa_r;
      `ANG_OFF_EXP: rd_mux = {14'h0000, exp_pr_r, 1'b0};
      `ANG_OFF_NPTX: rd_mux = nptx_r;
      `ANG_OFF_NPRX: rd_mux = nprx_r;
      `ANG_OFF_MSCTL: rd_mux = msctl_r;
      `ANG_OFF_MSST: rd_mux = msst_r;
      `ANG_OFF_SEED: rd_mux = {5'h00, seed_r};
      `ANG_OFF_EEEADV: rd_mux = eeeadv_r;
      `ANG_OFF_EEELP: rd_mux = eeelp_r;
      `ANG_OFF_EEECODE: rd_mux = eeecode_r;
      `ANG_OFF_PDFD: rd_mux = {14'h0000, pdfd_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  // bus handshakes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ANG_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `ANG_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awa_r         <= 8'h00;
      wd_r          <= 32'h00000000;
      ws_r          <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        awa_r         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        wd_r         <= s_axi_wdata;
        ws_r         <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= ang_hit(awa_r) ? `ANG_RESP_OKAY : `ANG_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_mux};
        s_axi_rresp   <= ang_hit(s_axi_araddr) ? `ANG_RESP_OKAY : `ANG_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // arbitration sequence and register file
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r        <= `ANG_RST_CTRL;
      adv_r         <= `ANG_RST_ADV;
      adv_act_r     <= `ANG_RST_ADV;
      lpa_r         <= 16'h0000;
      nptx_r        <= 16'h0000;
      nprx_r        <= 16'h0000;
      msctl_r       <= `ANG_RST_MSCTL;
      msst_r        <= 16'h0000;
      eeeadv_r      <= `ANG_RST_EEEADV;
      eeelp_r       <= 16'h0000;
      eeecode_r     <= 16'h0000;
      lpu1_r        <= 16'h0000;
      seed_r        <= `ANG_RST_SEED;
      pdfd_r        <= 2'b00;
      exp_pr_r      <= 1'b0;
      sw_rdy_r      <= 1'b0;
      st_r          <= S_DIS;
      tmr_r         <= {TW{1'b0}};
      cand100_r     <= 1'b0;
      pd_r          <= 1'b0;
      link_up_r     <= 1'b0;
      speed_r       <= 2'b00;
      full_duplex_r <= 1'b0;
    end else begin
      if (rd_go && s_axi_araddr == `ANG_OFF_EXP)
        exp_pr_r <= 1'b0;
      tmr_r <= tmr_r + ONE;
      case (st_r)
        S_DIS: begin
          link_up_r     <= link_ok;
          speed_r       <= {ctrl_r[`ANG_CTRL_SPH], ctrl_r[`ANG_CTRL_SPL]};
          full_duplex_r <= ctrl_r[`ANG_CTRL_DPX];
          if (an_en) begin
            st_r      <= S_ABIL;
            adv_act_r <= adv_r;
            link_up_r <= 1'b0;
          end
        end
        S_ABIL: begin
          tmr_r <= {TW{1'b0}};
          if (rx_ok) begin
            lpa_r <= rx_page;
            pd_r  <= 1'b0;
            st_r  <= S_GBM;
          end else if (!burst_ok_r && (rx_idle_100 || nlp_ok_r)) begin
            cand100_r <= rx_idle_100;
            pd_r      <= 1'b1;
            st_r      <= S_PD;
          end
        end
        S_GBM, S_GB1, S_GB2, S_EEM, S_EEU: begin
          if (rx_ok) begin
            nprx_r   <= rx_page;
            exp_pr_r <= 1'b1;
            st_r     <= st_r + 4'h1;
            if (st_r == S_GB1)
              lpu1_r <= rx_page;
            if (st_r == S_GB2) begin
              msst_r <= ms_res(msctl_r, seed_r, lpu1_r, rx_page);
              if (!eee_on)
                st_r <= sw_on ? S_SW : S_WAIT;
            end
            if (st_r == S_EEU) begin
              eeelp_r <= rx_page;
              st_r    <= sw_on ? S_SW : S_WAIT;
            end
          end
          tmr_r <= {TW{1'b0}};
        end
        S_SW: begin
          tmr_r <= {TW{1'b0}};
          if (rx_ok && sw_rdy_r) begin
            nprx_r   <= rx_page;
            exp_pr_r <= 1'b1;
            sw_rdy_r <= 1'b0;
            if (!nptx_r[`ANG_ADV_NP] && !rx_page[`ANG_ADV_NP])
              st_r <= S_WAIT;
          end
        end
        S_PD: begin
          if (rx_idle_100 != cand100_r || (!rx_idle_100 && !nlp_ok_r)) begin
            st_r      <= S_ABIL;
            adv_act_r <= adv_r;
          end else if (tmr_r == C_PD - 1) begin
            st_r  <= S_WAIT;
            tmr_r <= {TW{1'b0}};
          end
        end
        S_WAIT: begin
          if (tmr_r == C_LEW - 1) begin
            st_r      <= S_ABIL;
            adv_act_r <= adv_r;
            if (link_ok) begin
              st_r      <= S_UP;
              link_up_r <= 1'b1;
              if (pd_r) begin
                speed_r       <= {1'b0, cand100_r};
                full_duplex_r <= cand100_r ? pdfd_r[`ANG_PDFD_100] : pdfd_r[`ANG_PDFD_10];
              end else if (gfd) begin
                speed_r       <= 2'b10;
                full_duplex_r <= 1'b1;
              end else if (c100f || c100h) begin
                speed_r       <= 2'b01;
                full_duplex_r <= c100f;
              end else if (c10f || c10h) begin
                speed_r       <= 2'b00;
                full_duplex_r <= c10f;
              end else begin
                st_r      <= S_ABIL;
                link_up_r <= 1'b0;
              end
            end
          end
        end
        S_UP: begin
          if (!link_ok) begin
            st_r      <= S_ABIL;
            adv_act_r <= adv_r;
            link_up_r <= 1'b0;
          end
        end
        default: st_r <= S_DIS;
      endcase
      if (restart && an_en) begin
        st_r      <= S_ABIL;
        adv_act_r <= adv_r;
        link_up_r <= 1'b0;
        tmr_r     <= {TW{1'b0}};
      end
      if (!an_en && st_r != S_DIS)
        st_r <= S_DIS;
      if (wr_go) begin
        case (awa_r)
          `ANG_OFF_CTRL: ctrl_r <= wmerge(ctrl_r, wd_r, ws_r) & ~(16'h0001 << `ANG_CTRL_RST);
          `ANG_OFF_ADV: adv_r <= wmerge(adv_r, wd_r, ws_r);
          `ANG_OFF_NPTX: begin
            nptx_r   <= wmerge(nptx_r, wd_r, ws_r);
            sw_rdy_r <= 1'b1;
          end
          `ANG_OFF_MSCTL: msctl_r <= wmerge(msctl_r, wd_r, ws_r);
          `ANG_OFF_SEED: seed_r <= wd_r[10:0];
          `ANG_OFF_EEEADV: eeeadv_r <= wmerge(eeeadv_r, wd_r, ws_r);
          `ANG_OFF_EEECODE: eeecode_r <= wmerge(eeecode_r, wd_r, ws_r);
          `ANG_OFF_PDFD: pdfd_r <= wd_r[1:0];
          default: ;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> ang_autoneg_monitor.sv
/* port checker for ang_autoneg: bus handshakes, pulse shape, link bring-up;
   assumes one clock and the synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module ang_mon #(
  parameter int C_LEW = 300
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        link_ok,
  input wire logic        tx_pulse,
  input wire logic        link_up_r,
  input wire logic [1:0]  speed_r
);
  logic [31:0] up_cnt_r;
  // cycles since reset release
  always @(posedge aclk) up_cnt_r <= aresetn ? up_cnt_r + 32'h1 : 32'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_AFTER_W:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read upper half not zero");
  AST_TX_SINGLE: assert property (tx_pulse |=> !tx_pulse [*8])
    else $error("link pulse too long");
  AST_SPEED_LEGAL: assert property (link_up_r |-> speed_r != 2'b11)
    else $error("illegal speed");
  AST_UP_WAIT: assert property ($rose(link_up_r) |-> up_cnt_r > C_LEW)
    else $error("link up before wait");
  AST_UP_OK: assert property ($rose(link_up_r) |-> $past(link_ok))
    else $error("link up without healthy path");
endmodule
bind ang_autoneg ang_mon #(.C_LEW(C_LEW)) u_ang_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .link_ok(link_ok), .tx_pulse(tx_pulse), .link_up_r(link_up_r), .speed_r(speed_r));
`default_nettype wire

// >>> ang_autoneg_tb_top.sv
/* testbench: register reset values, bus errors, parallel detect duplex;
   assumes the far-end model and the bound checker */
`timescale 1ns/1ps
`default_nettype none
`include "ang_regs.vh"
module ang_autoneg_tb_top;
  localparam int C_PD = 300;
  localparam int C_LEW = 300;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, up_q = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rnd = 32'h68d8c89c;
  logic [1:0]  mode = 2'b00;
  logic [33:0] rq[$], bq[$], lq[$];
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  wire         awr, wrdy, bv, arr, rv, rxp, rxpv, rxi, lok, txp, up, fd;
  wire  [1:0]  bresp, rresp, spd;
  wire  [31:0] rdata;
  wire  [15:0] rxpg;
  always #12.5 aclk = ~aclk;
  ang_autoneg #(.C_BMIN(1000), .C_BMAX(20000), .C_NMIN(1000), .C_NMAX(20000), .C_PD(C_PD), .C_LEW(C_LEW))
  u_ang_autoneg (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .rx_pulse(rxp), .rx_page_valid(rxpv), .rx_page(rxpg), .rx_idle_100(rxi), .link_ok(lok),
    .tx_pulse(txp), .link_up_r(up), .speed_r(spd), .full_duplex_r(fd));
  ang_lp_model u_ang_lp_model (.aclk(aclk), .mode(mode), .rx_pulse(rxp), .rx_page_valid(rxpv),
    .rx_page(rxpg), .rx_idle_100(rxi), .link_ok(lok));
  function automatic [31:0] xs(input [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input [33:0] e, input [33:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] e);
    bq.push_back({32'h0, e});
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin @(posedge aclk); if (awr) awv <= 1'b0; if (wrdy) wv <= 1'b0; end while (!bv);
    br <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    rq.push_back(e);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin @(posedge aclk); if (arr) arv <= 1'b0; end while (!rv);
    rr <= 1'b0;
    @(posedge aclk);
  endtask
  // drop the link, then bring it up with the given far-end mode
  task automatic lk(input [1:0] m, input [2:0] e);
    int n = 0;
    mode <= 2'd0;
    do @(posedge aclk); while (up);
    lq.push_back({31'h0, e});
    mode <= m;
    do begin @(posedge aclk); n++; end while (!up);
    chk("bringup", 34'h1, {33'h0, n >= C_PD + C_LEW});
    @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    up_q <= up;
    if (rv && rr) chk("rdata", rq.pop_front(), {rresp, rdata});
    if (bv && br) chk("bresp", bq.pop_front(), {32'h0, bresp});
    if (up && !up_q) chk("mode", lq.pop_front(), {31'h0, spd, fd});
    if (cyc == 90000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`ANG_OFF_ADV, {18'h0, `ANG_RST_ADV});
    rd(`ANG_OFF_MSCTL, {18'h0, `ANG_RST_MSCTL});
    rd(`ANG_OFF_EEEADV, {18'h0, `ANG_RST_EEEADV});
    rd(`ANG_OFF_SEED, {23'h0, `ANG_RST_SEED});
    rd(8'h38, {`ANG_RESP_SLVERR, 32'h0});
    wr(8'h3c, 32'hffff, `ANG_RESP_SLVERR);
    repeat (3) begin
      rnd = xs(rnd);
      wr(`ANG_OFF_SEED, rnd, `ANG_RESP_OKAY);
      rd(`ANG_OFF_SEED, {23'h0, rnd[10:0]});
    end
    lk(2'd1, 3'b010);
    wr(`ANG_OFF_PDFD, 32'h1, `ANG_RESP_OKAY);
    lk(2'd2, 3'b001);
    lk(2'd1, 3'b010);
    wr(`ANG_OFF_PDFD, 32'h2, `ANG_RESP_OKAY);
    lk(2'd1, 3'b011);
    lk(2'd2, 3'b000);
    print_verdict;
  end
endmodule
`default_nettype wire

// >>> ang_flp.v
/*
  fast link pulse burst generator: 17 clock and 16 data slots per burst;
  assumes the page is held steady while enabled
*/
`timescale 1ns/1ps
`default_nettype none

module ang_flp #(
  parameter TW    = 26,
  parameter BURST = 640000,
  parameter PULSE = 2720
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        en,
  input  wire [15:0] page,
  output reg         pulse_r
);

  localparam [TW-1:0] ONE = 1;

  reg [TW-1:0] b_r;
  reg [TW-1:0] p_r;
  reg [5:0]    s_r;

  always @(posedge aclk) begin
    if (!aresetn || !en) begin
      b_r     <= {TW{1'b0}};
      p_r     <= {TW{1'b0}};
      s_r     <= 6'h00;
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= 1'b0;
      if (b_r == BURST - 1) begin
        b_r <= {TW{1'b0}};
        p_r <= {TW{1'b0}};
        s_r <= 6'h00;
      end else begin
        b_r <= b_r + ONE;
        if (s_r < 6'h21) begin
          if (p_r == {TW{1'b0}})
            pulse_r <= !s_r[0] || page[s_r[4:1]];
          if (p_r == PULSE - 1) begin
            p_r <= {TW{1'b0}};
            s_r <= s_r + 6'h01;
          end else begin
            p_r <= p_r + ONE;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> ang_ivl.v
/*
  interval checker: counts core clock cycles since the last event and
  flags an event whose spacing lies in [LO, HI]; assumes one-cycle events
*/
`timescale 1ns/1ps
`default_nettype none

module ang_ivl #(
  parameter TW = 26,
  parameter LO = 1,
  parameter HI = 2
) (
  input  wire aclk,
  input  wire aresetn,
  input  wire evt,
  output reg  hit_r,
  output wire over
);

  localparam [31:0]   SAT_W = HI + 1;
  localparam [TW-1:0] SAT   = SAT_W[TW-1:0];
  localparam [TW-1:0] ONE = 1;

  reg [TW-1:0] cnt_r;

  assign over = (cnt_r > HI);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= SAT;
      hit_r <= 1'b0;
    end else begin
      hit_r <= evt && (cnt_r >= LO) && (cnt_r <= HI);
      if (evt)
        cnt_r <= {TW{1'b0}};
      else if (cnt_r <= HI)
        cnt_r <= cnt_r + ONE;
    end
  end

endmodule

`default_nettype wire

// >>> ang_lp_model.sv
/* far-end model: silent, fixed 100 Mb/s signalling, or normal link pulses;
   assumes mode changes only after a clock edge */
`timescale 1ns/1ps
`default_nettype none
module ang_lp_model (
  input  wire logic       aclk,
  input  wire logic [1:0] mode,
  output var logic        rx_pulse,
  output wire logic       rx_page_valid,
  output var logic [15:0] rx_page,
  output var logic        rx_idle_100,
  output var logic        link_ok
);
  logic [13:0] gap_r;
  initial begin
    gap_r = 14'h0000;
    rx_pulse = 1'b0;
    rx_page = 16'h5a5a;
    rx_idle_100 = 1'b0;
    link_ok = 1'b0;
  end
  assign rx_page_valid = 1'b0;
  always @(posedge aclk) begin
    gap_r <= (gap_r == 14'h270f) ? 14'h0000 : gap_r + 14'h0001;
    rx_pulse <= (mode == 2'd2) && (gap_r == 12'd0);
    rx_idle_100 <= (mode == 2'd1);
    link_ok <= (mode != 2'd0);
    rx_page <= ~rx_page;
  end
endmodule
`default_nettype wire

// >>> ang_regs.vh
/*
  register map, field positions, reset values and timing counts of the
  auto-negotiation arbitration block; assumes a 40 MHz core clock
*/
`ifndef ANG_REGS_VH
`define ANG_REGS_VH

`define ANG_CLK_MHZ 40
`define ANG_CYC_US(x) ((x) * `ANG_CLK_MHZ)
`define ANG_CYC_NS_UP(x) (((x) * `ANG_CLK_MHZ + 999) / 1000)
`define ANG_CYC_NS_DN(x) (((x) * `ANG_CLK_MHZ) / 1000)

`define ANG_T_TXB_US 16000
`define ANG_T_TXP_US 68
`define ANG_T_FLPMIN_NS 17200
`define ANG_T_FLPMAX_US 185
`define ANG_T_RXBMIN_US 6800
`define ANG_T_RXBMAX_US 112000
`define ANG_T_DATMIN_NS 35400
`define ANG_T_DATMAX_US 95
`define ANG_T_NLPMIN_US 4500
`define ANG_T_NLPMAX_US 30000
`define ANG_T_PD_US 830000
`define ANG_T_LEW_US 1000000

`define ANG_OFF_CTRL 8'h00
`define ANG_OFF_STAT 8'h04
`define ANG_OFF_ADV 8'h08
`define ANG_OFF_LPA 8'h0c
`define ANG_OFF_EXP 8'h10
`define ANG_OFF_NPTX 8'h14
`define ANG_OFF_NPRX 8'h18
`define ANG_OFF_MSCTL 8'h1c
`define ANG_OFF_MSST 8'h20
`define ANG_OFF_SEED 8'h24
`define ANG_OFF_EEEADV 8'h28
`define ANG_OFF_EEELP 8'h2c
`define ANG_OFF_EEECODE 8'h30
`define ANG_OFF_PDFD 8'h34

`define ANG_CTRL_SPL 13
`define ANG_CTRL_ANEN 12
`define ANG_CTRL_RST 9
`define ANG_CTRL_DPX 8
`define ANG_CTRL_SPH 6
`define ANG_ADV_NP 15
`define ANG_ADV_100F 8
`define ANG_ADV_100H 7
`define ANG_ADV_10F 6
`define ANG_ADV_10H 5
`define ANG_EXP_PR 1
`define ANG_MS_MEN 12
`define ANG_MS_MVAL 11
`define ANG_MS_FD 9
`define ANG_MSST_FAULT 15
`define ANG_MSST_MASTER 14
`define ANG_MSST_LPFD 11
`define ANG_PDFD_100 1
`define ANG_PDFD_10 0

`define ANG_RST_CTRL 16'h1000
`define ANG_RST_ADV 16'h01e1
`define ANG_RST_MSCTL 16'h0200
`define ANG_RST_EEEADV 16'h0006
`define ANG_RST_SEED 11'h155

`define ANG_GB_CODE 11'h008
`define ANG_EEE_CODE 11'h00a
`define ANG_RESP_OKAY 2'b00
`define ANG_RESP_SLVERR 2'b10

`endif
